// file: shared/dtc_pkg.sv
// Purpose: constants, types and register map of the trigger control block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes:   level codes are signed fractions of the present full scale
package dtc_pkg;
  localparam int NCH    = 4;
  localparam int CIDX_W = $clog2(NCH);
  localparam int LVL_W  = 16;
  localparam int NLINE  = 8;
  localparam int SRC_W  = 5;
  localparam int RNG_W  = 3;
  localparam int NRNG   = 7;
  localparam int ADDR_W = 8;
  localparam int ERR_N  = 4;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MODE   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SLOPE  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_SOURCE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RANGE  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_LEVEL0 = 8'h20;

  // field positions
  localparam int CTRL_ARM    = 0;
  localparam int CTRL_FORCE  = 1;
  localparam int CTRL_ABORT  = 2;
  localparam int CTRL_CMDRST = 3;
  localparam int ST_ERR_LSB  = 4;
  localparam int E_IGN       = 0;
  localparam int E_LEVEL     = 1;
  localparam int E_RESCALE   = 2;
  localparam int E_CONFLICT  = 3;
  localparam int MODE_LSB    = 0;
  localparam int PAIR_LSB    = 4;
  localparam int SLP_VAL     = 0;
  localparam int SLP_SEL_LSB = 4;
  localparam int SLP_QUERY   = 8;
  localparam int SRC2_LSB    = 8;

  typedef enum logic [1:0] {
    ST_IDLE        = 2'b00,
    ST_WAIT_TRIG   = 2'b01,
    ST_WAIT_SAMPLE = 2'b10
  } dtc_state_t;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_MASTER = 2'b01,
    MODE_SLAVE  = 2'b10
  } dtc_mode_t;

  // trigger source codes
  localparam logic [SRC_W-1:0] SRC_OFF   = 5'h00;
  localparam logic [SRC_W-1:0] SRC_BUS   = 5'h01;
  localparam logic [SRC_W-1:0] SRC_EXT   = 5'h02;
  localparam logic [SRC_W-1:0] SRC_HOLD  = 5'h03;
  localparam logic [SRC_W-1:0] SRC_IMM   = 5'h04;
  localparam logic [SRC_W-1:0] SRC_INT1  = 5'h05;
  localparam logic [SRC_W-1:0] SRC_TTLT0 = 5'h09;
  localparam logic [SRC_W-1:0] SRC_LAST  = 5'h10;

  localparam logic SLOPE_POS = 1'b1;
  localparam logic SLOPE_NEG = 1'b0;

  localparam logic [SRC_W-1:0] RST_SRC1  = SRC_IMM;
  localparam logic [SRC_W-1:0] RST_SRC2  = SRC_HOLD;
  localparam logic [RNG_W-1:0] RST_RANGE = 3'h6;
  localparam logic signed [LVL_W-1:0] RST_LEVEL = 16'sh0000;
  localparam logic signed [LVL_W-1:0] LVL_FS    = 16'sh4000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic [31:0]       wdata;
  } dtc_apb_req_t;
endpackage

// file: core/dtc_core.sv
// Purpose: trigger control of a multichannel digitizer behind an APB slave
// Assumes: channel samples and sample tick come from logic on CLK_SYS_IN
// Notes:   backplane lines are active low, shared with peer modules
`timescale 1ns/1ps

// Overview of operation
// - force trigger while waiting jumps to sampling
// - force trigger otherwise ignored, error raised
// - per-channel level used by channel level sources
// - level writes outside present span rejected
// - range change keeps level fraction of scale
// - rescaled level clamped to span, error raised
// - positive slope fires upward on levels, negative downward
// - command reset zeroes all levels
// - level writes refused while armed
// - level of a channel readable
// - normal uses sources; master/slave binds lines
// - pair n uses line n sample, n+1 trigger
// - mode readable, writable while armed
// - two slopes; unnamed slope command targets one
// - slope one positive, zero negative
// - slope matters only for level or external
// - command reset sets both slopes positive
// - slope query reports named source, default one
// - external input fires on falling edge at positive slope, rising at negative
module dtc_core
  import dtc_pkg::*;
#(
  parameter logic signed [LVL_W-1:0] LVL_LIM [NRNG] = '{default: LVL_FS}
) (
  // clock and reset
  input  wire logic                   CLK_SYS_IN,
  input  wire logic                   RESET_N_IN,
  // apb slave
  input  wire logic                   PSEL_IN,
  input  wire logic                   PENABLE_IN,
  input  wire logic                   PWRITE_IN,
  input  wire logic [ADDR_W-1:0]      PADDR_IN,
  input  wire logic [31:0]            PWDATA_IN,
  output logic      [31:0]            PRDATA_OUT,
  output logic                        PREADY_OUT,
  output logic                        PSLVERR_OUT,
  // channel samples and sample timing
  input  wire logic [NCH*LVL_W-1:0]   CH_SAMPLE_IN,
  input  wire logic                   CH_VALID_IN,
  input  wire logic                   SAMPLE_TICK_IN,
  // external trigger pin
  input  wire logic                   EXT_TRIG_N_IN,
  // backplane sync lines
  input  wire logic [NLINE-1:0]       BP_LINE_IN,
  output logic      [NLINE-1:0]       BP_LINE_OUT,
  output logic      [NLINE-1:0]       BP_LINE_OE_N_OUT,
  // trigger status
  output logic                        TRIG_EVENT_OUT,
  output logic                        MEAS_START_OUT,
  output logic      [1:0]             ARM_STATE_OUT
);
  dtc_apb_req_t             req;
  dtc_state_t               state;
  dtc_mode_t                mode;
  logic [1:0]               pair;
  logic [SRC_W-1:0]         src1;
  logic [SRC_W-1:0]         src2;
  logic [1:0]               slope;
  logic                     slope_named;
  logic [RNG_W-1:0]         range_sel;
  logic signed [LVL_W-1:0]  level [NCH];
  logic signed [LVL_W-1:0]  prev  [NCH];
  logic signed [LVL_W-1:0]  samp  [NCH];
  logic                     prev_ok;
  logic [ERR_N-1:0]         err;
  logic [ERR_N-1:0]         set_err;
  logic                     pready;
  logic                     xfer;
  logic                     hit;
  logic [31:0]              rd_data;
  logic                     wr_ctrl, wr_status, wr_mode, wr_slope;
  logic                     wr_source, wr_range, wr_level;
  logic [CIDX_W-1:0]        lvl_idx;
  logic                     cmd_arm, cmd_force, cmd_abort, cmd_rst;
  logic [NLINE-1:0]         bp_s1, bp_s2, bp_s3;
  logic                     ext_s1, ext_s2, ext_s3;
  logic [NLINE-1:0]         line_fall;
  logic                     ext_fall, ext_rise;
  logic [NCH-1:0]           cross_up, cross_dn;
  logic [31:0]              ev_pos, ev_neg;
  logic                     ev1, ev2, trig_hit, sample_ev, fire_local;
  logic [2:0]               trig_line, samp_line;
  logic [NLINE-1:0]         next_drive;
  logic signed [LVL_W-1:0]  wr_lvl, lim_cur, lim_new;
  logic [RNG_W-1:0]         new_rng;
  logic [1:0]               new_mode;
  logic [2:0]               new_pair;
  logic [SRC_W-1:0]         new_src1, new_src2;
  logic [1:0]               slp_sel;

  assign req.addr  = PADDR_IN;
  assign req.write = PWRITE_IN;
  assign req.wdata = PWDATA_IN;

  // apb: one wait state, effects at the edge where pready is high
  assign xfer = PSEL_IN & PENABLE_IN & pready;
  assign lvl_idx = req.addr[CIDX_W+1:2];

  always_comb begin
    wr_ctrl   = 1'b0;
    wr_status = 1'b0;
    wr_mode   = 1'b0;
    wr_slope  = 1'b0;
    wr_source = 1'b0;
    wr_range  = 1'b0;
    wr_level  = 1'b0;
    hit       = 1'b1;
    rd_data   = 32'h0000_0000;
    if (req.addr == OFS_CTRL) begin
      wr_ctrl = 1'b1;
      rd_data[1:0] = state;
    end else if (req.addr == OFS_STATUS) begin
      wr_status = 1'b1;
      rd_data[1:0] = state;
      rd_data[ST_ERR_LSB +: ERR_N] = err;
    end else if (req.addr == OFS_MODE) begin
      wr_mode = 1'b1;
      rd_data[MODE_LSB +: 2] = mode;
      rd_data[PAIR_LSB +: 3] = {pair, 1'b0};
    end else if (req.addr == OFS_SLOPE) begin
      wr_slope = 1'b1;
      rd_data[0] = slope_named ? slope[1] : slope[0];
      rd_data[2:1] = slope;
    end else if (req.addr == OFS_SOURCE) begin
      wr_source = 1'b1;
      rd_data[0 +: SRC_W] = src1;
      rd_data[SRC2_LSB +: SRC_W] = src2;
    end else if (req.addr == OFS_RANGE) begin
      wr_range = 1'b1;
      rd_data[RNG_W-1:0] = range_sel;
    end else if ((req.addr[ADDR_W-1:CIDX_W+2] ==
                  OFS_LEVEL0[ADDR_W-1:CIDX_W+2]) &&
                 (req.addr[1:0] == 2'b00)) begin
      wr_level = 1'b1;
      rd_data = {{(32-LVL_W){level[lvl_idx][LVL_W-1]}},
                 level[lvl_idx]};
    end else begin
      hit = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pready      <= 1'b0;
      PRDATA_OUT  <= 32'h0000_0000;
      PSLVERR_OUT <= 1'b0;
    end else begin
      pready      <= PSEL_IN & PENABLE_IN & ~pready;
      PSLVERR_OUT <= PSEL_IN & PENABLE_IN & ~pready & ~hit;
      if (PSEL_IN & PENABLE_IN & ~pready) begin
        PRDATA_OUT <= (hit && !req.write) ? rd_data : 32'h0000_0000;
      end
    end
  end
  assign PREADY_OUT = pready;

  // command strobes, qualified by a completed, decoded write
  assign cmd_arm   = xfer & req.write & wr_ctrl & req.wdata[CTRL_ARM];
  assign cmd_force = xfer & req.write & wr_ctrl & req.wdata[CTRL_FORCE];
  assign cmd_abort = xfer & req.write & wr_ctrl & req.wdata[CTRL_ABORT];
  assign cmd_rst   = xfer & req.write & wr_ctrl & req.wdata[CTRL_CMDRST];

  assign wr_lvl   = req.wdata[LVL_W-1:0];
  assign lim_cur  = LVL_LIM[range_sel];
  assign new_rng  = req.wdata[RNG_W-1:0];
  assign lim_new  = (new_rng < RNG_W'(NRNG)) ? LVL_LIM[new_rng] : LVL_FS;
  assign new_mode = req.wdata[MODE_LSB +: 2];
  assign new_pair = req.wdata[PAIR_LSB +: 3];
  assign new_src1 = req.wdata[0 +: SRC_W];
  assign new_src2 = req.wdata[SRC2_LSB +: SRC_W];
  assign slp_sel  = req.wdata[SLP_SEL_LSB +: 2];

  // pin and backplane synchronisers; the third stage is for edges
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      bp_s1  <= '1;
      bp_s2  <= '1;
      bp_s3  <= '1;
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      ext_s3 <= 1'b1;
    end else begin
      bp_s1  <= BP_LINE_IN;
      bp_s2  <= bp_s1;
      bp_s3  <= bp_s2;
      ext_s1 <= EXT_TRIG_N_IN;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end
  assign line_fall = bp_s3 & ~bp_s2;
  assign ext_fall  = ext_s3 & ~ext_s2;
  assign ext_rise  = ~ext_s3 & ext_s2;

  // level crossing from consecutive samples
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      samp[c] = CH_SAMPLE_IN[c*LVL_W +: LVL_W];
      cross_up[c] = CH_VALID_IN & prev_ok &
                    (prev[c] < level[c]) & (samp[c] >= level[c]);
      cross_dn[c] = CH_VALID_IN & prev_ok &
                    (prev[c] > level[c]) & (samp[c] <= level[c]);
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      prev_ok <= 1'b0;
      for (int c = 0; c < NCH; c++) begin
        prev[c] <= RST_LEVEL;
      end
    end else if (CH_VALID_IN) begin
      prev_ok <= 1'b1;
      for (int c = 0; c < NCH; c++) begin
        prev[c] <= samp[c];
      end
    end
  end

  // source events by code; slope only steers level and external
  always_comb begin
    ev_pos = 32'h0000_0000;
    ev_neg = 32'h0000_0000;
    ev_pos[SRC_IMM] = 1'b1;
    ev_neg[SRC_IMM] = 1'b1;
    ev_pos[SRC_EXT] = ext_fall;
    ev_neg[SRC_EXT] = ext_rise;
    for (int c = 0; c < NCH; c++) begin
      ev_pos[SRC_INT1 + c] = cross_up[c];
      ev_neg[SRC_INT1 + c] = cross_dn[c];
    end
    for (int l = 0; l < NLINE; l++) begin
      ev_pos[SRC_TTLT0 + l] = line_fall[l];
      ev_neg[SRC_TTLT0 + l] = line_fall[l];
    end
  end

  assign ev1 = slope[0] ? ev_pos[src1] : ev_neg[src1];
  assign ev2 = slope[1] ? ev_pos[src2] : ev_neg[src2];
  assign samp_line = {pair, 1'b0};
  assign trig_line = {pair, 1'b1};
  assign fire_local = (state == ST_WAIT_TRIG) && (mode == MODE_MASTER) &&
                      (cmd_force || ev2);

  always_comb begin
    if (mode == MODE_NORMAL) begin
      trig_hit  = ev1 | ev2;
      sample_ev = SAMPLE_TICK_IN;
    end else begin
      trig_hit  = line_fall[trig_line] | ev2;
      sample_ev = line_fall[samp_line];
    end
  end

  // arm state machine
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state <= ST_IDLE;
    end else if (cmd_rst || cmd_abort) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmd_arm) begin
            state <= ST_WAIT_TRIG;
          end
        end
        ST_WAIT_TRIG: begin
          if (cmd_force || trig_hit) begin
            state <= ST_WAIT_SAMPLE;
          end
        end
        ST_WAIT_SAMPLE: begin
          if (sample_ev) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      TRIG_EVENT_OUT <= 1'b0;
      MEAS_START_OUT <= 1'b0;
      ARM_STATE_OUT  <= ST_IDLE;
    end else begin
      TRIG_EVENT_OUT <= (state == ST_WAIT_TRIG) && (cmd_force || trig_hit)
                        && !cmd_rst && !cmd_abort;
      MEAS_START_OUT <= (state == ST_WAIT_SAMPLE) && sample_ev
                        && !cmd_rst && !cmd_abort;
      ARM_STATE_OUT  <= state;
    end
  end

  // master drives its pair low; slaves only listen
  always_comb begin
    next_drive = '0;
    if (mode == MODE_MASTER) begin
      next_drive[samp_line] = SAMPLE_TICK_IN;
      next_drive[trig_line] = fire_local;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      BP_LINE_OUT      <= '1;
      BP_LINE_OE_N_OUT <= '1;
    end else begin
      BP_LINE_OUT      <= ~next_drive;
      BP_LINE_OE_N_OUT <= ~next_drive;
    end
  end

  // error flags: a new event wins over write-one-to-clear
  always_comb begin
    set_err = '0;
    set_err[E_IGN] = cmd_force && (state != ST_WAIT_TRIG);
    if (xfer && req.write && wr_level) begin
      if (state != ST_IDLE) begin
        set_err[E_CONFLICT] = 1'b1;
      end else if ((wr_lvl > lim_cur) || (wr_lvl < -lim_cur)) begin
        set_err[E_LEVEL] = 1'b1;
      end
    end
    if (xfer && req.write && wr_range) begin
      if (new_rng >= RNG_W'(NRNG)) begin
        set_err[E_CONFLICT] = 1'b1;
      end else begin
        for (int c = 0; c < NCH; c++) begin
          if ((level[c] > lim_new) || (level[c] < -lim_new)) begin
            set_err[E_RESCALE] = 1'b1;
          end
        end
      end
    end
    if (xfer && req.write && wr_mode &&
        ((new_mode == 2'b11) || new_pair[0])) begin
      set_err[E_CONFLICT] = 1'b1;
    end
    if (xfer && req.write && wr_source &&
        ((new_src1 > SRC_LAST) || (new_src2 > SRC_LAST) ||
         ((mode != MODE_NORMAL) && (new_src1 != src1)))) begin
      set_err[E_CONFLICT] = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      err <= '0;
    end else if (xfer && req.write && wr_status) begin
      err <= (err & ~req.wdata[ST_ERR_LSB +: ERR_N]) | set_err;
    end else begin
      err <= err | set_err;
    end
  end

  // trigger levels
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      for (int c = 0; c < NCH; c++) begin
        level[c] <= RST_LEVEL;
      end
    end else if (cmd_rst) begin
      for (int c = 0; c < NCH; c++) begin
        level[c] <= RST_LEVEL;
      end
    end else if (xfer && req.write && wr_level && (state == ST_IDLE) &&
                 (wr_lvl <= lim_cur) && (wr_lvl >= -lim_cur)) begin
      level[lvl_idx] <= wr_lvl;
    end else if (xfer && req.write && wr_range &&
                 (new_rng < RNG_W'(NRNG))) begin
      // code is a fraction of full scale, so it carries over as is unless outside the new span, where it is clamped
      for (int c = 0; c < NCH; c++) begin
        if (level[c] > lim_new) begin
          level[c] <= lim_new;
        end else if (level[c] < -lim_new) begin
          level[c] <= -lim_new;
        end else begin
          level[c] <= level[c];
        end
      end
    end
  end

  // range, mode, sources and slopes
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      range_sel <= RST_RANGE;
    end else if (cmd_rst) begin
      range_sel <= RST_RANGE;
    end else if (xfer && req.write && wr_range &&
                 (new_rng < RNG_W'(NRNG))) begin
      range_sel <= new_rng;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mode <= MODE_NORMAL;
      pair <= 2'b00;
    end else if (cmd_rst) begin
      mode <= MODE_NORMAL;
    end else if (xfer && req.write && wr_mode &&
                 (new_mode != 2'b11) && !new_pair[0]) begin
      mode <= dtc_mode_t'(new_mode);
      pair <= new_pair[2:1];
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      src1 <= RST_SRC1;
      src2 <= RST_SRC2;
    end else if (cmd_rst) begin
      src1 <= RST_SRC1;
      src2 <= RST_SRC2;
    end else if (xfer && req.write && wr_source) begin
      if ((new_src1 <= SRC_LAST) && (mode == MODE_NORMAL)) begin
        src1 <= new_src1;
      end
      if (new_src2 <= SRC_LAST) begin
        src2 <= new_src2;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      slope       <= {SLOPE_POS, SLOPE_POS};
      slope_named <= 1'b0;
    end else if (cmd_rst) begin
      slope       <= {SLOPE_POS, SLOPE_POS};
      slope_named <= 1'b0;
    end else if (xfer && req.write && wr_slope) begin
      slope_named <= (slp_sel == 2'b10);
      if (!req.wdata[SLP_QUERY]) begin
        if (slp_sel == 2'b10) begin
          slope[1] <= req.wdata[SLP_VAL];
        end else begin
          slope[0] <= req.wdata[SLP_VAL];
        end
      end
    end
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);

  a_force_moves: assert property (
    (state == ST_WAIT_TRIG) && cmd_force && !cmd_rst && !cmd_abort
    |=> (state == ST_WAIT_SAMPLE) ##1 $past(TRIG_EVENT_OUT))
    else $error("force while waiting did not start sampling");
  a_force_ignored: assert property (
    cmd_force && (state != ST_WAIT_TRIG)
    |=> err[E_IGN] && (state != ST_WAIT_SAMPLE || $past(state) != ST_IDLE))
    else $error("ignored force did not raise its error");
  a_level_armed: assert property (
    xfer && req.write && wr_level && (state != ST_IDLE) && !cmd_rst
    |=> (level[$past(lvl_idx)] == $past(level[lvl_idx])) && err[E_CONFLICT])
    else $error("level changed while armed");
  a_level_span: assert property (
    xfer && req.write && wr_level && (state == ST_IDLE) && !cmd_rst &&
    (wr_lvl > lim_cur)
    |=> err[E_LEVEL] && (level[$past(lvl_idx)] != $past(wr_lvl)))
    else $error("out of span level accepted");
  a_rescale_clamp: assert property (
    xfer && req.write && wr_range && !cmd_rst &&
    (new_rng < RNG_W'(NRNG)) && (level[0] > lim_new)
    |=> (level[0] == $past(lim_new)) && err[E_RESCALE])
    else $error("rescaled level not clamped");
  a_cmd_defaults: assert property (
    cmd_rst |=> (level[0] == RST_LEVEL) && (level[NCH-1] == RST_LEVEL) &&
    (slope == 2'b11) && (mode == MODE_NORMAL) && (state == ST_IDLE))
    else $error("command reset defaults wrong");
  a_cross_up: assert property (
    (mode == MODE_NORMAL) && (src1 == SRC_INT1) && slope[0] &&
    (state == ST_WAIT_TRIG) && cross_up[0] && !cmd_rst && !cmd_abort
    |=> (state == ST_WAIT_SAMPLE))
    else $error("upward crossing did not trigger");
  a_cross_once: assert property (
    cross_up[0] && !(xfer && req.write) |=> !cross_up[0])
    else $error("crossing fired twice in a row");
  a_ext_fall: assert property (
    (mode == MODE_NORMAL) && (src1 == SRC_EXT) && slope[0] &&
    (state == ST_WAIT_TRIG) && ext_fall && !cmd_rst && !cmd_abort
    |=> (state == ST_WAIT_SAMPLE))
    else $error("external falling edge missed");
  a_master_lines: assert property (
    (mode == MODE_MASTER) && SAMPLE_TICK_IN
    |=> !BP_LINE_OE_N_OUT[{$past(pair), 1'b0}] &&
        !BP_LINE_OUT[{$past(pair), 1'b0}])
    else $error("master did not drive its sample line");
  a_src1_locked: assert property (
    xfer && req.write && wr_source && (mode != MODE_NORMAL) && !cmd_rst
    |=> $stable(src1))
    else $error("source one changed outside normal mode");
  a_slope_unnamed: assert property (
    xfer && req.write && wr_slope && (slp_sel == 2'b00) &&
    !req.wdata[SLP_QUERY] && !cmd_rst
    |=> (slope[0] == $past(req.wdata[SLP_VAL])) && $stable(slope[1]))
    else $error("unnamed slope command missed source one");

  c_arm_trig: cover property (
    (state == ST_IDLE) ##1 (state == ST_WAIT_TRIG) ##[1:20] MEAS_START_OUT);
  c_force: cover property ((state == ST_WAIT_TRIG) && cmd_force);
  c_master: cover property ((mode == MODE_MASTER) && fire_local);
  c_rescale: cover property (set_err[E_RESCALE]);
endmodule

// file: sim/dtc_peer.sv
// Purpose: peer module on the shared backplane lines
// Assumes: open-drain lines with a pull-up, same clock
// Notes:   holds a line low for one cycle per request
`timescale 1ns/1ps
module dtc_peer (
  // line drive
  input  wire logic       clk_in,
  input  wire logic [7:0] pull_in,
  output logic      [7:0] drive_n_out = 8'hFF
);
  // peer pulls low each line whose pull_in bit is set, one cycle later
  always @(posedge clk_in) drive_n_out <= ~pull_in;
endmodule

// file: sim/dtc_core_tb_top.sv
// Purpose: self-checking bench of the trigger control block
// Assumes: apb master leaves one idle cycle between transfers
// Notes:   range 0 span is shrunk to reach the rescale clamp
`timescale 1ns/1ps
module dtc_core_tb_top;
  import dtc_pkg::*;
  logic             clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0;
  logic             tick = 0, prdy, perr, err, trg, meas;
  logic [7:0]       padr = '0;
  logic             vld = 1'b0, extn = 1'b1;
  logic [15:0]      ch0 = '0;
  logic [31:0]      pwd = '0, prd, rd;
  logic [7:0]       bpo, oe_n, pdrv_n, line, pull = '0;
  logic [1:0]       ast;
  int               fail_count = 0, checks_done = 0, cyc = 0;
  int               ntrg = 0, nmeas = 0, oe2 = 0;
  assign line = (bpo | oe_n) & pdrv_n;
  dtc_core #(.LVL_LIM('{0: 16'sh1000, default: LVL_FS})) uut (
    .CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(padr),
    .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
    .PSLVERR_OUT(perr), .CH_SAMPLE_IN({48'h0000_0000_0000, ch0}),
    .CH_VALID_IN(vld), .SAMPLE_TICK_IN(tick), .EXT_TRIG_N_IN(extn),
    .BP_LINE_IN(line),
    .BP_LINE_OUT(bpo), .BP_LINE_OE_N_OUT(oe_n), .TRIG_EVENT_OUT(trg),
    .MEAS_START_OUT(meas), .ARM_STATE_OUT(ast));
  dtc_peer peer (.clk_in(clk), .pull_in(pull), .drive_n_out(pdrv_n));
  initial forever #12.5 clk = ~clk;
  // pulses are counted mid-cycle, where they have settled
  always @(negedge clk) begin
    cyc++;
    ntrg += (trg === 1'b1);
    nmeas += (meas === 1'b1);
    oe2 += (oe_n[2] === 1'b0 && bpo[2] === 1'b0);
    if (cyc == 3000) begin
      fail_count++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    checks_done++;
    fail_count += (s !== e);
    if (s !== e) $display("wrong value %s exp %h seen %h", nm, e, s);
  endtask
  task automatic rchk(string nm, logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, '0);
    chk(nm, e, rd);
  endtask
  task automatic t_reset;
    rchk("slopes", OFS_SLOPE, 32'h7);
    rchk("mode", OFS_MODE, 32'h0);
    rchk("level3", OFS_LEVEL0 + 8'h0C, 32'h0);
    apb(1'b0, 8'h40, '0);
    chk("slverr", 1, err);
    apb(1'b1, OFS_CTRL, 32'h2);
    rchk("ignored", OFS_STATUS, 32'h10);
    apb(1'b1, OFS_STATUS, 32'hF0);
    $display("test reset done");
  endtask
  task automatic t_level;
    apb(1'b1, OFS_LEVEL0, 32'h2000);
    rchk("level", OFS_LEVEL0, 32'h2000);
    apb(1'b1, OFS_LEVEL0, 32'h4001);
    rchk("span err", OFS_STATUS, 32'h20);
    rchk("kept", OFS_LEVEL0, 32'h2000);
    apb(1'b1, OFS_RANGE, 32'h3);
    rchk("rescaled", OFS_LEVEL0, 32'h2000);
    apb(1'b1, OFS_RANGE, 32'h0);
    rchk("clamped", OFS_LEVEL0, 32'h1000);
    rchk("clamp err", OFS_STATUS, 32'h60);
    apb(1'b1, OFS_STATUS, 32'hF0);
    $display("test level done");
  endtask
  task automatic t_arm;
    apb(1'b1, OFS_SOURCE, 32'h303);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_LEVEL0, 32'h0800);
    rchk("locked", OFS_LEVEL0, 32'h1000);
    apb(1'b1, OFS_CTRL, 32'h2);
    chk("trig", 1, ntrg);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    repeat (3) @(posedge clk);
    chk("meas", 1, nmeas);
    $display("test arm done");
  endtask
  task automatic t_slope;
    apb(1'b1, OFS_SLOPE, 32'h0);
    rchk("slope1", OFS_SLOPE, 32'h4);
    apb(1'b1, OFS_SLOPE, 32'h20);
    rchk("slope2", OFS_SLOPE, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h8);
    rchk("rst slope", OFS_SLOPE, 32'h7);
    rchk("rst level", OFS_LEVEL0, 32'h0);
    $display("test slope done");
  endtask
  task automatic t_cross;
    apb(1'b1, OFS_SOURCE, 32'h305);
    apb(1'b1, OFS_LEVEL0, 32'h100);
    apb(1'b1, OFS_CTRL, 32'h1);
    vld <= 1'b1;
    ch0 <= 16'h0000;
    @(posedge clk);
    ch0 <= 16'h0200;
    repeat (2) @(posedge clk);
    vld <= 1'b0;
    rchk("rise", OFS_CTRL, 32'h2);
    chk("arm state", 2, ast);
    apb(1'b1, OFS_CTRL, 32'h4);
    apb(1'b1, OFS_SLOPE, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
    vld <= 1'b1;
    ch0 <= 16'h0000;
    @(posedge clk);
    vld <= 1'b0;
    rchk("fall", OFS_CTRL, 32'h2);
    apb(1'b1, OFS_CTRL, 32'h4);
    apb(1'b1, OFS_SLOPE, 32'h1);
    apb(1'b1, OFS_SOURCE, 32'h302);
    apb(1'b1, OFS_CTRL, 32'h1);
    extn <= 1'b0;
    repeat (4) @(posedge clk);
    extn <= 1'b1;
    rchk("ext", OFS_CTRL, 32'h2);
    apb(1'b1, OFS_CTRL, 32'h8);
    $display("test cross done");
  endtask
  task automatic t_master;
    apb(1'b1, OFS_SOURCE, 32'h303);
    apb(1'b1, OFS_MODE, 32'h21);
    rchk("mode", OFS_MODE, 32'h21);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    repeat (3) @(posedge clk);
    chk("sample line", 1, oe2);
    apb(1'b1, OFS_CTRL, 32'h1);
    pull <= 8'h08;
    @(posedge clk);
    pull <= 8'h00;
    repeat (8) @(posedge clk);
    chk("line trig", 5, ntrg);
    $display("test master done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_level;
    t_arm;
    t_slope;
    t_cross;
    t_master;
    final_report;
  end
endmodule
